// ---- logic/pct_pkg.sv ----
`default_nettype none
package pct_pkg;

  // ----------------------------------------------------------------
  // Clocking and prescaler
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 50_000_000;  // System clock
  localparam int unsigned TICK_HZ      = 8192;        // Base tick rate
  localparam int unsigned TICK_DIV_CYC = CLK_HZ / TICK_HZ;
  localparam logic [5:0]  LAST_OF_64   = 6'h3F;       // 4096->64, 64->1
  localparam logic [5:0]  LAST_OF_60   = 6'h3B;       // 1 Hz -> 1/60 Hz

  // ----------------------------------------------------------------
  // Serial interface identity
  // ----------------------------------------------------------------
  // Arbitrary bus address value, not tied to any part
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;

  // ----------------------------------------------------------------
  // Register offsets, field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_TWO       = 8'h01;
  localparam logic [7:0] ADDR_COUNTDOWN_CONTROL = 8'h0E;
  localparam logic [7:0] ADDR_COUNTDOWN_VALUE   = 8'h0F;
  localparam int unsigned CTL_EN_BIT   = 7;   // countdown_enable
  localparam int unsigned CTL_SEL_LSB  = 0;   // source_clock_select [1:0]
  localparam int unsigned C2_TIE_BIT   = 0;   // countdown_irq_enable
  localparam int unsigned C2_FLAG_BIT  = 2;   // countdown_flag
  localparam int unsigned C2_LPS_BIT   = 4;   // level_or_pulse_select
  localparam logic       RST_EN        = 1'b0;
  localparam logic [1:0] RST_SEL       = 2'h3;
  localparam logic [7:0] RST_VALUE     = 8'h00;
  localparam logic       RST_C2_BIT    = 1'b0;

  // ----------------------------------------------------------------
  // Source clock codes and pulse_auto_reset_time in 8192 Hz ticks
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_4096HZ = 2'h0;
  localparam logic [1:0] SRC_64HZ   = 2'h1;
  localparam logic [1:0] SRC_1HZ    = 2'h2;
  localparam logic [1:0] SRC_1_60HZ = 2'h3;
  localparam logic [7:0] RTN_122US_TICKS   = 8'h01;
  localparam logic [7:0] RTN_244US_TICKS   = 8'h02;
  localparam logic [7:0] RTN_7813US_TICKS  = 8'h40;
  localparam logic [7:0] RTN_15625US_TICKS = 8'h80;

  // Aligned one-cycle tick enables from the prescaler
  typedef struct packed {
    logic t8192;
    logic t4096;
    logic t64;
    logic t1;
    logic t60;
  } pct_tick_s;

  // One committed register write from the serial interface
  typedef struct packed {
    logic       ctl;
    logic       val;
    logic       c2;
    logic [7:0] data;
  } pct_wr_s;

endpackage
`default_nettype wire

// ---- logic/pct_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pct_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // Three-stage capture with agreement filter
  // ----------------------------------------------------------------
  logic [W-1:0] s1_r;   // Metastability catcher, read only by s2
  logic [W-1:0] s2_r;   // Second stage
  logic [W-1:0] s3_r;   // Third stage
  logic [W-1:0] q_nxt;  // Filtered level next value

  // A bit changes only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : q_o[i];
    end
  end

  // Pins idle high on an open-drain bus, so reset to one
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      q_o  <= '1;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- logic/pct_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module pct_prescaler #(
  parameter int unsigned DIV_CYC = pct_pkg::TICK_DIV_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  output pct_pkg::pct_tick_s     tick_o
);

  // ----------------------------------------------------------------
  // Divider chain state
  // ----------------------------------------------------------------
  logic [15:0]        div_r;    // Cycles within one 8192 Hz tick
  logic [15:0]        div_nxt;
  logic               ph_r;     // Halves 8192 Hz into 4096 Hz
  logic               ph_nxt;
  logic [5:0]         c64_r;    // 4096 Hz ticks per 64 Hz tick
  logic [5:0]         c64_nxt;
  logic [5:0]         c1_r;     // 64 Hz ticks per 1 Hz tick
  logic [5:0]         c1_nxt;
  logic [5:0]         c60_r;    // 1 Hz ticks per minute
  logic [5:0]         c60_nxt;
  pct_pkg::pct_tick_s tick_nxt;

  // Every slower tick coincides with a faster one, so all periods
  // of the timer start on the same 8192 Hz boundary
  always_comb
  begin
    tick_nxt.t8192 = (div_r == 16'(DIV_CYC - 1));
    tick_nxt.t4096 = tick_nxt.t8192 && ph_r;
    tick_nxt.t64   = tick_nxt.t4096 && (c64_r == pct_pkg::LAST_OF_64);
    tick_nxt.t1    = tick_nxt.t64 && (c1_r == pct_pkg::LAST_OF_64);
    tick_nxt.t60   = tick_nxt.t1 && (c60_r == pct_pkg::LAST_OF_60);
    div_nxt = tick_nxt.t8192 ? 16'h0000 : div_r + 16'h0001;
    ph_nxt  = tick_nxt.t8192 ? !ph_r : ph_r;
    c64_nxt = tick_nxt.t4096 ? c64_r + 6'h01 : c64_r;
    c1_nxt  = tick_nxt.t64 ? c1_r + 6'h01 : c1_r;
    c60_nxt = tick_nxt.t1 ? (tick_nxt.t60 ? 6'h00 : c60_r + 6'h01)
                          : c60_r;
  end

  // Free running; never reset by the timer so periods stay exact
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r  <= 16'h0000;
      ph_r   <= 1'b0;
      c64_r  <= 6'h00;
      c1_r   <= 6'h00;
      c60_r  <= 6'h00;
      tick_o <= '0;
    end
    else
    begin
      div_r  <= div_nxt;
      ph_r   <= ph_nxt;
      c64_r  <= c64_nxt;
      c1_r   <= c1_nxt;
      c60_r  <= c60_nxt;
      tick_o <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- logic/pct_timer.sv ----
// Overview of operation
// R1: Host clears enable, irq enable, flag first
// R2: Value register doubles as one RAM byte
// R3: Select code picks 4096, 64, 1, 1/60 Hz
// R4: Counting starts on ack clock after write
// R5: Later periods last reload times source period
// R6: First period uncertain by one source period
// R7: Slow sources share the same first-period bound
// R8: Reload 1..255 valid, zero halts counting
// R9: Terminal count sets flag; only host clears
// R10: Reading value register returns live count
// R11: Host reads counter twice and compares
// R12: Irq enable gates pin; mode picks pulse/level
// R13: Level pin follows flag, one interrupt only
// R14: Disabled irq terminal count leaves pin high
// R15: Level mode: enable low stops, pin kept
// R16: Level mode: clearing flag releases pin
// R17: Pulse mode pulses every count, sets flag
// R18: At zero, event fires and counter reloads
// R19: Pulse lasts auto-reset time, self-releases
// R20: Pulse mode: flag clear keeps running pulse
// R21: Pulse mode: irq enable low releases pin
// R22: Pulse mode: enable low stops, pulse finishes
// R23: Pulse width from source and reload one
// R24: Control: enable bit 7, select bits 1:0
// R25: Control two: irq enable 0, flag 2, mode 4
// R26: Interface writes synchronised before use
`timescale 1ns/1ps
`default_nettype none
module pct_timer #(
  parameter int unsigned DIV_CYC  = pct_pkg::TICK_DIV_CYC,
  parameter logic [6:0]  DEV_ADDR = pct_pkg::DEV_ADDR_DFLT
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      int_n
);

  // ----------------------------------------------------------------
  // Pin capture and edge detection
  // ----------------------------------------------------------------
  logic [1:0]         pin_f;     // Filtered {scl, sda}
  logic [1:0]         prev_r;    // Filtered levels one cycle ago
  logic               scl_rise;
  logic               scl_fall;
  logic               start_c;   // Start or repeated start
  logic               stop_c;
  pct_pkg::pct_tick_s tick;

  // R26 interface sync
  pct_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pin_f)
  );

  pct_prescaler #(
    .DIV_CYC (DIV_CYC)
  ) u_presc (
    .clock  (clock),
    .rst_n  (rst_n),
    .tick_o (tick)
  );

  // Bus conditions on the filtered levels only
  always_comb
  begin
    scl_rise = pin_f[1] && !prev_r[1];
    scl_fall = !pin_f[1] && prev_r[1];
    start_c  = pin_f[1] && prev_r[1] && prev_r[0] && !pin_f[0];
    stop_c   = pin_f[1] && prev_r[1] && !prev_r[0] && pin_f[0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r <= 2'h3;
    end
    else
    begin
      prev_r <= pin_f;
    end
  end

  // ----------------------------------------------------------------
  // Timer register state
  // ----------------------------------------------------------------
  logic             en_r, en_nxt;         // countdown_enable
  logic [1:0]       sel_r, sel_nxt;       // source_clock_select
  logic [7:0]       reload_r, reload_nxt; // Preset value
  logic [7:0]       cnt_r, cnt_nxt;       // Live countdown
  logic             tie_r, tie_nxt;       // countdown_irq_enable
  logic             flag_r, flag_nxt;     // countdown_flag
  logic             lps_r, lps_nxt;       // level_or_pulse_select
  logic [7:0]       pulse_r, pulse_nxt;   // Ticks left of the pulse
  logic             int_n_nxt;
  logic             src_tick;             // Selected source tick
  logic             tc_w;                 // Terminal count event
  logic             start_w;              // Enable rising by write
  logic [7:0]       plen_w;               // Pulse length for now
  pct_pkg::pct_wr_s wr_r, wr_nxt;         // Committed write

  // Read view of the three registers
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    unique case (a)
      pct_pkg::ADDR_CONTROL_TWO:
      begin
        b[pct_pkg::C2_TIE_BIT]  = tie_r;
        b[pct_pkg::C2_FLAG_BIT] = flag_r;
        b[pct_pkg::C2_LPS_BIT]  = lps_r;
      end
      pct_pkg::ADDR_COUNTDOWN_CONTROL:
      begin
        b[pct_pkg::CTL_EN_BIT] = en_r;
        b[pct_pkg::CTL_SEL_LSB +: 2] = sel_r;
      end
      // R10 live count
      pct_pkg::ADDR_COUNTDOWN_VALUE: b = cnt_r;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ADACK, I_PTR, I_PACK, I_WR, I_WACK, I_RD, I_RACK
  } pct_i2c_e;

  pct_i2c_e   st_r, st_nxt;
  logic [2:0] bc_r, bc_nxt;   // Bit within the byte
  logic [7:0] sh_r, sh_nxt;   // Shift register both ways
  logic [7:0] ptr_r, ptr_nxt; // Register pointer, auto increments
  logic       rw_r, rw_nxt;   // Read direction of this transfer
  logic       oe_r, oe_nxt;   // Pulls SDA low while set
  logic [7:0] rd_w;           // Byte to send next

  // Data shifts on SCL rise, SDA changes only after SCL falls
  always_comb
  begin
    st_nxt  = st_r;
    bc_nxt  = bc_r;
    sh_nxt  = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt  = rw_r;
    oe_nxt  = oe_r;
    wr_nxt  = '0;
    rd_w    = rd_byte(ptr_r);
    if (start_c)
    begin
      st_nxt = I_ADDR;
      bc_nxt = 3'h0;
      oe_nxt = 1'b0;
    end
    else if (stop_c)
    begin
      st_nxt = I_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        I_IDLE: ;
        // Receive a byte of address, pointer or data
        I_ADDR, I_PTR, I_WR:
          if (scl_rise)
          begin
            sh_nxt = {sh_r[6:0], pin_f[0]};
            bc_nxt = bc_r + 3'h1;
            if (bc_r == 3'h7)
            begin
              if (st_r == I_PTR)
                st_nxt = I_PACK;
              else if (st_r == I_WR)
                st_nxt = I_WACK;
              else if (sh_r[6:0] == DEV_ADDR)
              begin
                st_nxt = I_ADACK;
                rw_nxt = pin_f[0];
              end
              else
                st_nxt = I_IDLE;
            end
          end
        // Acknowledge: drive on first fall; on the second release, or for a read drive the first data bit
        I_ADACK, I_PACK, I_WACK:
        begin
          if (scl_rise && oe_r && st_r == I_PACK)
            ptr_nxt = sh_r;
          // R4 commit on ack clock rise
          if (scl_rise && oe_r && st_r == I_WACK)
          begin
            wr_nxt.ctl  = (ptr_r == pct_pkg::ADDR_COUNTDOWN_CONTROL);
            wr_nxt.val  = (ptr_r == pct_pkg::ADDR_COUNTDOWN_VALUE);
            wr_nxt.c2   = (ptr_r == pct_pkg::ADDR_CONTROL_TWO);
            wr_nxt.data = sh_r;
            ptr_nxt     = ptr_r + 8'h01;
          end
          if (scl_fall && !oe_r)
            oe_nxt = 1'b1;
          else if (scl_fall && st_r == I_ADACK && rw_r)
          begin
            st_nxt = I_RD;
            sh_nxt = rd_w;
            oe_nxt = !rd_w[7];
            bc_nxt = 3'h0;
          end
          else if (scl_fall)
          begin
            oe_nxt = 1'b0;
            st_nxt = (st_r == I_ADACK) ? I_PTR : I_WR;
          end
        end
        // Transmit: next bit after each fall, release after eight
        I_RD:
          if (scl_fall && bc_r == 3'h7)
          begin
            oe_nxt = 1'b0;
            st_nxt = I_RACK;
          end
          else if (scl_fall)
          begin
            bc_nxt = bc_r + 3'h1;
            sh_nxt = {sh_r[6:0], 1'b0};
            oe_nxt = !sh_r[6];
          end
        // Host acknowledge; a high level ends the read
        I_RACK:
          if (scl_rise)
          begin
            ptr_nxt = ptr_r + 8'h01;
            if (pin_f[0])
              st_nxt = I_IDLE;
          end
          else if (scl_fall)
          begin
            st_nxt = I_RD;
            sh_nxt = rd_w;
            oe_nxt = !rd_w[7];
            bc_nxt = 3'h0;
          end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r   <= I_IDLE;
      bc_r   <= 3'h0;
      sh_r   <= 8'h00;
      ptr_r  <= 8'h00;
      rw_r   <= 1'b0;
      oe_r   <= 1'b0;
      wr_r   <= '0;
      sda_o  <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      bc_r   <= bc_nxt;
      sh_r   <= sh_nxt;
      ptr_r  <= ptr_nxt;
      rw_r   <= rw_nxt;
      oe_r   <= oe_nxt;
      wr_r   <= wr_nxt;
      sda_o  <= 1'b0;
      sda_oe <= oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Countdown, flag and interrupt pin
  // ----------------------------------------------------------------
  always_comb
  begin
    // R3 source select
    unique case (sel_r)
      pct_pkg::SRC_4096HZ: src_tick = tick.t4096;
      pct_pkg::SRC_64HZ:   src_tick = tick.t64;
      pct_pkg::SRC_1HZ:    src_tick = tick.t1;
      pct_pkg::SRC_1_60HZ: src_tick = tick.t60;
    endcase
    // R23 pulse width
    unique case (sel_r)
      pct_pkg::SRC_4096HZ:
        plen_w = (reload_r == 8'h01) ? pct_pkg::RTN_122US_TICKS
                                     : pct_pkg::RTN_244US_TICKS;
      pct_pkg::SRC_64HZ:
        plen_w = (reload_r == 8'h01) ? pct_pkg::RTN_7813US_TICKS
                                     : pct_pkg::RTN_15625US_TICKS;
      default: plen_w = pct_pkg::RTN_15625US_TICKS;
    endcase
    // R18 decrement from one is the event
    tc_w    = en_r && src_tick && (cnt_r == 8'h01);
    start_w = wr_r.ctl && wr_r.data[pct_pkg::CTL_EN_BIT] && !en_r;
    // R24 control fields
    en_nxt  = wr_r.ctl ? wr_r.data[pct_pkg::CTL_EN_BIT] : en_r;
    sel_nxt = wr_r.ctl ? wr_r.data[pct_pkg::CTL_SEL_LSB +: 2] : sel_r;
    // R25 control two fields
    tie_nxt = wr_r.c2 ? wr_r.data[pct_pkg::C2_TIE_BIT] : tie_r;
    lps_nxt = wr_r.c2 ? wr_r.data[pct_pkg::C2_LPS_BIT] : lps_r;
    // R2 plain storage
    reload_nxt = wr_r.val ? wr_r.data : reload_r;
    // Idle counter mirrors the preset so reads see the stored byte;
    // a value write takes effect at once even while running
    if (wr_r.val)
      cnt_nxt = wr_r.data;
    // R4 R6 R7 R15 start load or hold
    else if (start_w || !en_r)
      cnt_nxt = reload_r;
    // R18 auto reload
    else if (tc_w)
      cnt_nxt = reload_r;
    // R8 zero halts; R5 one step per source tick
    else if (src_tick && cnt_r != 8'h00)
      cnt_nxt = cnt_r - 8'h01;
    else
      cnt_nxt = cnt_r;
    // R9 set wins over a clear in the same cycle
    flag_nxt = flag_r;
    if (wr_r.c2 && !wr_r.data[pct_pkg::C2_FLAG_BIT])
      flag_nxt = 1'b0;
    if (tc_w)
      flag_nxt = 1'b1;
    // R17 R19 pulse on every event
    if (tc_w && lps_r && tie_r)
      pulse_nxt = plen_w;
    // R21 irq enable off cuts the pulse
    else if (!tie_r)
      pulse_nxt = 8'h00;
    // R20 R22 pulse runs out on its own
    else if (tick.t8192 && pulse_r != 8'h00)
      pulse_nxt = pulse_r - 8'h01;
    else
      pulse_nxt = pulse_r;
    // R12 R13 R14 R16 gate and mode
    int_n_nxt = !(tie_r && (lps_r ? (pulse_r != 8'h00) : flag_r));
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_r     <= pct_pkg::RST_EN;
      sel_r    <= pct_pkg::RST_SEL;
      reload_r <= pct_pkg::RST_VALUE;
      cnt_r    <= pct_pkg::RST_VALUE;
      tie_r    <= pct_pkg::RST_C2_BIT;
      flag_r   <= pct_pkg::RST_C2_BIT;
      lps_r    <= pct_pkg::RST_C2_BIT;
      pulse_r  <= 8'h00;
      int_n    <= 1'b1;
    end
    else
    begin
      en_r     <= en_nxt;
      sel_r    <= sel_nxt;
      reload_r <= reload_nxt;
      cnt_r    <= cnt_nxt;
      tie_r    <= tie_nxt;
      flag_r   <= flag_nxt;
      lps_r    <= lps_nxt;
      pulse_r  <= pulse_nxt;
      int_n    <= int_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_flag_set: assert property (tc_w |=> flag_r) // R9
    else $error("flag not set at terminal count");
  a_flag_kept: assert property ( // R9
    flag_r && !(wr_r.c2 && !wr_r.data[pct_pkg::C2_FLAG_BIT]) |=> flag_r)
    else $error("flag dropped without host clear");
  a_reload_tc: assert property ( // R18
    tc_w && !wr_r.val |=> cnt_r == $past(reload_r))
    else $error("counter did not reload");
  a_zero_halt: assert property ( // R8
    en_r && cnt_r == 8'h00 && !wr_r.val && !wr_r.ctl |=> cnt_r == 8'h00)
    else $error("zero count moved");
  a_start_load: assert property (start_w |=> cnt_r == $past(reload_r)) // R4
    else $error("start did not load preset");
  a_stop_count: assert property (!en_r |=> !$rose(flag_r)) // R15
    else $error("flag rose while stopped");
  a_tie_gate: assert property (!tie_r |=> int_n) // R12
    else $error("pin low with irq enable off");
  a_level_pin: assert property ( // R16
    !lps_r && tie_r |=> int_n == !$past(flag_r))
    else $error("level pin not following flag");
  a_pulse_len: assert property ( // R23
    tc_w && lps_r && tie_r |=> pulse_r == $past(plen_w) ##1 !int_n)
    else $error("pulse width or start wrong");

  c_pulse_event: cover property (tc_w && lps_r && tie_r);
  c_level_event: cover property (tc_w && !lps_r && tie_r);
  c_start: cover property (start_w);
  c_pulse_end: cover property (!int_n && lps_r ##1 int_n);

endmodule
`default_nettype wire

// ---- dv/pct_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-wire bus host: drives the clock line, only ever pulls data low
module pct_host_model #(
  parameter logic [6:0] ADDR = pct_pkg::DEV_ADDR_DFLT
) (
  input  wire logic clock,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_in
);
  // Quarter bit in clocks; eight-clock phases are the least that the
  // device's three-stage pin filter resolves with margin
  localparam int unsigned Q = 4;
  int nacks;                // Bytes the device failed to acknowledge
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    nacks = 0;
  end
  // Pins move only just after a rising clock edge
  task automatic qtr();
    begin
      repeat (Q) @(posedge clock);
    end
  endtask
  // Waits before raising the clock, so a late ack release is no stop
  task automatic start();
    begin
      qtr();
      sda_low <= 1'b0;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_low <= 1'b1;
      qtr();
      scl <= 1'b0;
    end
  endtask
  task automatic stop();
    begin
      qtr();
      sda_low <= 1'b1;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_low <= 1'b0;
      qtr();
    end
  endtask
  // One bit: data set in the low phase, sampled late in the high phase
  task automatic bit_x(input logic b, output logic s);
    begin
      qtr();
      sda_low <= ~b;
      qtr();
      scl <= 1'b1;
      qtr();
      qtr();
      s = sda_in;
      scl <= 1'b0;
    end
  endtask
  task automatic put(input logic [7:0] d);
    logic s;
    begin
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'b1, s);
      if (s !== 1'b0) nacks++;
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    begin
      start();
      put({ADDR, 1'b0});
      put(p);
      put(d);
      stop();
    end
  endtask
  // Single byte read; the host answers the last byte with no ack
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic a;
    begin
      start();
      put({ADDR, 1'b0});
      put(p);
      start();
      put({ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(1'b1, a);
      stop();
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_low, sda_o, sda_oe, int_n, sda, int_d;
  int bad_count = 0, checked = 0, cyc = 0, nf = 0, lf = 0, pf = 0, wid = 0;
  int t0;
  logic [7:0] v, w;
  // Open-drain data line with pull-up
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  always #10 clock = ~clock;
  pct_timer #(.DIV_CYC(4)) uut (.clock(clock), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n));
  pct_host_model host (.clock(clock), .scl(scl), .sda_low(sda_low),
    .sda_in(sda));
  // Edge monitor on the interrupt pin, times in clock cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    int_d <= int_n;
    if (int_d === 1'b1 && int_n === 1'b0)
    begin
      nf <= nf + 1;
      pf <= lf;
      lf <= cyc;
    end
    if (int_d === 1'b0 && int_n === 1'b1)
      wid <= cyc - lf;
  end
  task automatic chkreg(input string n, input logic [7:0] p,
                        input logic [7:0] e);
    begin
      host.rd(p, v);
      `CHK(n, e, v)
    end
  endtask
  // Bounded wait; a missed event shows up in the following compare
  task automatic wait_falls(input int k);
    int t;
    begin
      t = nf + k;
      for (int i = 0; i < 4000 && nf < t; i++) @(posedge clock);
    end
  endtask
  task automatic pulse_run(input logic [1:0] s, input logic [7:0] n,
                           input int per, input int lo);
    begin
      host.wr(8'h0E, {6'h00, s});
      host.wr(8'h01, 8'h00);
      host.wr(8'h0F, n);
      host.wr(8'h01, 8'h11);
      host.wr(8'h0E, {1'b1, 5'h00, s});
      t0 = cyc;
      wait_falls(1);
      if (per > 900) `CHK("first", 1'b1, lf-t0 >= 480 && lf-t0 <= 1030)
      wait_falls(2);
      `CHK("period", per, lf - pf)
      repeat (lo + 8) @(posedge clock);
      `CHK("width", lo, wid)
    end
  endtask
  task automatic summarize();
    begin
      if (bad_count == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog: about twice the expected length of the whole run
  initial
  begin
    #1_800_000;
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    chkreg("ctl_rst", 8'h0E, 8'h03);
    chkreg("c2_rst", 8'h01, 8'h00);
    chkreg("unmapped", 8'h05, 8'h00);
    host.wr(8'h0F, 8'hA5);
    chkreg("ram", 8'h0F, 8'hA5);
    host.wr(8'h01, 8'hFF);
    chkreg("c2_bits", 8'h01, 8'h11);
    for (int s = 0; s < 4; s++)
    begin
      host.wr(8'h0E, 8'h7C | 8'(s));
      chkreg("sel", 8'h0E, 8'(s));
    end
    pulse_run(2'h0, 8'h01, 8, 4);
    pulse_run(2'h0, 8'h03, 24, 8);
    pulse_run(2'h1, 8'h01, 512, 256);
    pulse_run(2'h1, 8'h02, 1024, 512);
    // Writes land inside a running pulse
    wait_falls(1);
    host.wr(8'h01, 8'h11);
    repeat (100) @(posedge clock);
    `CHK("flag_clr", 512, wid)
    wait_falls(1);
    t0 = nf;
    host.wr(8'h0E, 8'h01);
    repeat (100) @(posedge clock);
    `CHK("stop_w", 512, wid)
    chkreg("stop_flag", 8'h01, 8'h15);
    repeat (1100) @(posedge clock);
    `CHK("stopped", t0, nf)
    host.wr(8'h0E, 8'h81);
    wait_falls(1);
    host.wr(8'h01, 8'h14);
    `CHK("tie_off", 1'b1, int_n)
    host.wr(8'h0F, 8'hC8);
    repeat (2600) @(posedge clock);
    host.rd(8'h0F, v);
    host.rd(8'h0F, w);
    `CHK("live", 1'b1, w < 8'hC8 && w <= v)
    // Level mode
    host.wr(8'h0E, 8'h01);
    host.wr(8'h01, 8'h00);
    host.wr(8'h0F, 8'h01);
    host.wr(8'h0E, 8'h81);
    repeat (1200) @(posedge clock);
    `CHK("no_irq", 1'b1, int_n)
    chkreg("flag", 8'h01, 8'h04);
    host.wr(8'h01, 8'h00);
    host.wr(8'h01, 8'h01);
    wait_falls(1);
    t0 = nf;
    repeat (1200) @(posedge clock);
    `CHK("one_irq", t0, nf)
    `CHK("level", 1'b0, int_n)
    host.wr(8'h0E, 8'h01);
    chkreg("flag_kept", 8'h01, 8'h05);
    `CHK("pin_kept", 1'b0, int_n)
    host.wr(8'h01, 8'h01);
    `CHK("released", 1'b1, int_n)
    host.wr(8'h0F, 8'h00);
    host.wr(8'h0E, 8'h81);
    t0 = nf;
    repeat (1500) @(posedge clock);
    `CHK("zero", t0, nf)
    `CHK("nacks", 0, host.nacks)
    summarize();
  end
endmodule
`default_nettype wire
